// ==== common/burst_flash_regs.svh ====
/*
  Constants for the burst flash read interface: counter widths, reset
  values and timing counts. Assumes a 50 MHz system clock.
*/
`ifndef BURST_FLASH_REGS_SVH
`define BURST_FLASH_REGS_SVH

`define CLK_PERIOD_NS       20
`define BURST_CNT_W         5
`define BURST_CNT_RESET     5'h00
`define BURST_CNT_LAST      5'h1f
`define ADDR_W              19
`define DATA_W              16
`define SLEEP_EXTRA_NS      30
`define ACC_NS              80
`define SLEEP_CYCLES        ((`ACC_NS + `SLEEP_EXTRA_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_MIN_NS        500
`define RESET_MIN_CYCLES    ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READY_NS            20000
`define READY_CYCLES        (`READY_NS / `CLK_PERIOD_NS)
`define RH_NS               50
`define RH_CYCLES           ((`RH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STATUS_TOGGLE_BIT   6
`define STATUS_POLL_BIT     7
`define ID_MFR_OFFSET       2'h0
`define ID_DEV_OFFSET       2'h1
`define ID_BURST_OFFSET     2'h3

`endif

// ==== common/burst_flash_pkg.sv ====
/*
  Types for the burst flash read interface.
  Assumes the constants header is included by the design files.
*/
package burst_flash_pkg;

  typedef enum logic [1:0] {
    MODE_ARRAY  = 2'b00,
    MODE_AUTOSEL = 2'b01,
    MODE_BYPASS = 2'b10
  } cmd_mode_t;

  typedef enum logic [1:0] {
    OP_NONE    = 2'b00,
    OP_PROGRAM = 2'b01,
    OP_ERASE   = 2'b10
  } op_kind_t;

endpackage : burst_flash_pkg

// ==== design/sync2.sv ====
/*
  Two-stage synchroniser for a bus of pin levels.
  Assumes inputs are asynchronous to sys_clk.
*/
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  logic [W-1:0] meta;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta  <= '1;
      level <= '1;
    end else begin
      meta  <= pin;
      level <= meta;
    end
  end
endmodule : sync2

// ==== design/burst_counter.sv ====
/*
  Five-bit burst word counter with wrap and last-word flag.
  Assumes load and advance already synchronised to sys_clk.
*/
`timescale 1ns/100ps
`include "burst_flash_regs.svh"
module burst_counter (
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    clear,
  input  wire logic                    load,
  input  wire logic                    step,
  output logic [`BURST_CNT_W-1:0]      count,
  output logic                         at_last
);
  always_ff @(posedge sys_clk) begin
    if (sys_rst || clear || load) begin
      count <= `BURST_CNT_RESET;
    end else if (step) begin
      count <= count + 5'h01;
    end
  end

  assign at_last = (count == `BURST_CNT_LAST);

  a_count_wraps: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (step && !load && !clear && at_last) |=> count == 5'h00)
    else $error("burst counter did not wrap");
endmodule : burst_counter

// ==== design/burst_flash_read_interface.sv ====
/*
  Device-side control of a burst-read parallel flash: mode tracking,
  burst address sequencing, suspend/resume, command decode, status,
  standby, sleep and hardware reset. The array is outside: it gets
  array_addr and returns array_data. Pins are asynchronous and are
  sampled through two flip-flops; burst clock edges are detected on
  the synchronised level, so the burst clock must run well below 25 MHz.
*/
// How it works
// - In asynchronous mode the clock, load and advance pins are ignored.
// - Burst mode starts only after the burst-enable command sequence.
// - First word after initial access; later words after each clock edge.
// - Counter clears to zero on load, increments per edge with advance low.
// - At counter all ones the last word shows with the end flag low.
// - Advance past the last word wraps the low five address bits.
// - Chip select high ends the burst but keeps burst mode.
// - Burst-disable command stops the burst and returns to async mode.
// - Hardware reset low aborts everything and returns to async mode.
// - The software reset command leaves burst mode untouched.
// - Output gate and advance high float outputs, word held inside.
// - Output gate low alone drives the same held word.
// - Gate and advance low resume; next edge gives the next word.
// - Unlock bypass programs a word in two writes instead of four.
// - Autoselect returns identification codes on the low data byte.
// - During program or erase, reads outside an active burst return status on the low byte.
// - Standby floats outputs; deselected program or erase keeps going.
// - Stable address for access time plus 30 ns enters sleep.
// - Reset low floats outputs, ignores accesses, returns to array read.
// - Reset during program keeps busy low until the ready time.
`timescale 1ns/100ps
`include "burst_flash_regs.svh"
module burst_flash_read_interface
  import burst_flash_pkg::*;
#(
  parameter int          READY_CYCLES = `READY_CYCLES,
  parameter int          OP_CYCLES    = 5000,
  parameter int          IACC_CYCLES  = 4,
  parameter logic [15:0] MFR_ID       = 16'h00a5, // Arbitrary value
  parameter logic [15:0] DEV_ID       = 16'h005a  // Arbitrary value
) (
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  input  wire logic                chip_select_n,
  input  wire logic                output_gate_n,
  input  wire logic                write_strobe_n,
  input  wire logic                hw_reset_n,
  input  wire logic                burst_clk,
  input  wire logic                start_address_load_n,
  input  wire logic                burst_advance_n,
  input  wire logic [`ADDR_W-1:0]  addr,
  input  wire logic [`DATA_W-1:0]  data_in,
  input  wire logic [`DATA_W-1:0]  array_data,
  output logic      [`DATA_W-1:0]  data_out,
  output logic                     data_oe_n,
  output logic      [`ADDR_W-1:0]  array_addr,
  output logic                     last_word_flag_n,
  output logic                     ready_busy_n,
  output logic                     burst_mode,
  output logic                     asleep,
  output logic                     prog_req,
  output logic      [`DATA_W-1:0]  prog_data
);
  localparam int SLEEP_CYC = `SLEEP_CYCLES;
  localparam int RH_CYC    = `RH_CYCLES;

  typedef struct packed {
    logic                    burst;
    cmd_mode_t               mode;
    logic                    bypass;
    logic [2:0]              seq;
    op_kind_t                op;
    logic [15:0]             op_cnt;
    logic [15:0]             rdy_cnt;
    logic [3:0]              rh_cnt;
    logic                    in_burst;
    logic [3:0]              iacc;
    logic [`ADDR_W-1:0]      base;
    logic [`BURST_CNT_W-1:0] offs;
    logic [`DATA_W-1:0]      word;
    logic                    word_ok;
    logic                    word_last;
    logic                    toggle;
    logic [`ADDR_W-1:0]      last_addr;
    logic [3:0]              stable;
    logic                    we_prev;
    logic                    clk_prev;
    logic                    prog;
    logic [`DATA_W-1:0]      pdata;
  } state_t;

  state_t cur, next_cur;

  logic [6:0] pins;
  logic ce_n, oe_n, we_n, rst_n, bclk, load_n, adv_n;
  sync2 #(.W(7)) u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pin     ({chip_select_n, output_gate_n, write_strobe_n, hw_reset_n,
               burst_clk, start_address_load_n, burst_advance_n}),
    .level   (pins)
  );
  assign {ce_n, oe_n, we_n, rst_n, bclk, load_n, adv_n} = pins;

  logic edge_r, ld, stp, cnt_clear, at_last;
  logic [`BURST_CNT_W-1:0] count;
  logic wr_end;
  logic [7:0] cmd;

  assign edge_r = bclk && !cur.clk_prev;
  assign ld  = cur.burst && !ce_n && edge_r && !load_n;
  assign stp = cur.burst && cur.in_burst && !ce_n && edge_r
               && load_n && !adv_n;
  assign cnt_clear = !rst_n || !cur.burst;
  assign wr_end = !cur.we_prev && we_n && !ce_n && oe_n;
  assign cmd = data_in[7:0];

  burst_counter u_cnt (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .clear   (cnt_clear),
    .load    (ld),
    .step    (stp),
    .count   (count),
    .at_last (at_last)
  );

  function automatic logic [15:0] dec_sat(input logic [15:0] v);
    dec_sat = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
  endfunction : dec_sat

  always_comb begin
    next_cur          = cur;
    next_cur.we_prev  = we_n;
    next_cur.clk_prev = bclk;
    next_cur.prog     = 1'b0;
    next_cur.op_cnt   = dec_sat(cur.op_cnt);
    next_cur.rdy_cnt  = dec_sat(cur.rdy_cnt);
    next_cur.rh_cnt   = (cur.rh_cnt == 4'h0) ? 4'h0 : cur.rh_cnt - 4'h1;
    if (cur.op != OP_NONE && cur.op_cnt == 16'h0001) begin
      next_cur.op = OP_NONE;
    end
    if (cur.op != OP_NONE) begin
      next_cur.toggle = ~cur.toggle;
    end
    // Sleep counter; free of control pins by design
    if (addr != cur.last_addr) begin
      next_cur.last_addr = addr;
      next_cur.stable    = 4'h0;
    end else if (cur.stable != 4'(SLEEP_CYC)) begin
      next_cur.stable = cur.stable + 4'h1;
    end
    if (!rst_n) begin
      next_cur.burst    = 1'b0;
      next_cur.in_burst = 1'b0;
      next_cur.mode     = MODE_ARRAY;
      next_cur.bypass   = 1'b0;
      next_cur.seq      = 3'h0;
      next_cur.word_ok  = 1'b0;
      next_cur.rh_cnt   = 4'(RH_CYC);
      if (cur.op != OP_NONE) begin
        next_cur.op      = OP_NONE;
        next_cur.rdy_cnt = 16'(READY_CYCLES);
      end
    end else begin
      if (ce_n) begin
        next_cur.in_burst = 1'b0;
      end
      if (ld) begin
        next_cur.base     = addr;
        next_cur.in_burst = 1'b1;
        next_cur.iacc     = 4'(IACC_CYCLES);
        next_cur.word_ok  = 1'b0;
      end else if (cur.iacc != 4'h0) begin
        next_cur.iacc = cur.iacc - 4'h1;
        if (cur.iacc == 4'h1) begin
          next_cur.word      = array_data;
          next_cur.word_ok   = 1'b1;
          next_cur.word_last = at_last;
        end
      end else if (cur.in_burst && cur.word_ok) begin
        next_cur.word      = array_data;
        next_cur.word_last = at_last;
      end
      if (wr_end && cur.rh_cnt == 4'h0) begin
        unique case (cur.seq)
          3'h0: begin
            if (cmd == 8'hf0) begin
              next_cur.mode = MODE_ARRAY;
            end else if (cur.bypass && cmd == 8'ha0) begin
              next_cur.seq = 3'h3;
            end else if (cmd == 8'haa) begin
              next_cur.seq = 3'h1;
            end
          end
          3'h1: next_cur.seq = (cmd == 8'h55) ? 3'h2 : 3'h0;
          3'h2: begin
            next_cur.seq = 3'h0;
            unique case (cmd)
              8'h90: next_cur.mode   = MODE_AUTOSEL;
              8'h20: next_cur.bypass = 1'b1;
              8'ha0: next_cur.seq    = 3'h3;
              8'h80: next_cur.seq    = 3'h4;
              8'h78: next_cur.burst  = 1'b1;
              8'h70: begin
                next_cur.burst    = 1'b0;
                next_cur.in_burst = 1'b0;
              end
              default: next_cur.mode = MODE_ARRAY;
            endcase
          end
          3'h3: begin
            next_cur.seq    = 3'h0;
            next_cur.prog   = 1'b1;
            next_cur.pdata  = data_in;
            next_cur.op     = OP_PROGRAM;
            next_cur.op_cnt = 16'(OP_CYCLES);
          end
          3'h4: next_cur.seq = (cmd == 8'haa) ? 3'h5 : 3'h0;
          3'h5: next_cur.seq = (cmd == 8'h55) ? 3'h6 : 3'h0;
          3'h6: begin
            next_cur.seq = 3'h0;
            if (cmd == 8'h10 || cmd == 8'h30) begin
              next_cur.op     = OP_ERASE;
              next_cur.op_cnt = 16'(OP_CYCLES);
            end
          end
          default: next_cur.seq = 3'h0;
        endcase
        if (cur.bypass && cur.seq == 3'h0 && cmd == 8'h90) begin
          next_cur.seq = 3'h7;
        end
        if (cur.seq == 3'h7) begin
          next_cur.seq    = 3'h0;
          next_cur.bypass = (cmd != 8'h00);
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cur         <= '0;
      cur.we_prev <= 1'b1;
      cur.clk_prev <= 1'b1; // Synced clock resets high: no false edge
      cur.mode    <= MODE_ARRAY;
      cur.op      <= OP_NONE;
    end else begin
      cur <= next_cur;
    end
  end

  logic [`DATA_W-1:0] rd_val;
  logic               burst_drive, rd_ok;
  always_comb begin
    rd_val = array_data;
    if (cur.op != OP_NONE) begin
      rd_val = {8'h00, 1'b0, cur.toggle, 6'h00};
    end else if (cur.mode == MODE_AUTOSEL) begin
      unique case (addr[1:0])
        `ID_MFR_OFFSET:   rd_val = {8'h00, MFR_ID[7:0]};
        `ID_DEV_OFFSET:   rd_val = {8'h00, DEV_ID[7:0]};
        `ID_BURST_OFFSET: rd_val = {15'h0000, cur.burst};
        default:          rd_val = 16'h0000;
      endcase
    end
  end

  assign burst_drive = cur.burst && cur.in_burst && cur.word_ok;
  assign rd_ok = rst_n && !ce_n && !oe_n && we_n && cur.rh_cnt == 4'h0;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      data_out         <= 16'h0000;
      data_oe_n        <= 1'b1;
      last_word_flag_n <= 1'b1;
    end else begin
      data_oe_n        <= !rd_ok;
      data_out         <= burst_drive ? cur.word : rd_val;
      last_word_flag_n <= !(rd_ok && burst_drive && cur.word_last);
    end
  end

  assign array_addr = cur.burst && cur.in_burst
                    ? {cur.base[`ADDR_W-1:`BURST_CNT_W],
                       cur.base[`BURST_CNT_W-1:0] + count}
                    : addr;
  assign ready_busy_n = (cur.op == OP_NONE) && (cur.rdy_cnt == 16'h0000);
  assign burst_mode   = cur.burst;
  assign asleep       = (cur.stable == 4'(SLEEP_CYC));
  assign prog_req     = cur.prog;
  assign prog_data    = cur.pdata;

  a_async_ignores: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !cur.burst |-> !ld && !stp)
    else $error("burst pins acted in async mode");
  a_reset_exits: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !rst_n |=> !cur.burst && cur.mode == MODE_ARRAY)
    else $error("reset did not leave burst mode");
  a_reset_floats: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !rst_n |=> data_oe_n)
    else $error("outputs driven during reset");
  a_deselect_ends: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce_n && rst_n |=> !cur.in_burst && data_oe_n)
    else $error("burst survived chip deselect");
  a_flag_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !$past(at_last, 2) |-> last_word_flag_n)
    else $error("end flag low off the last word");
  a_suspend_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (burst_drive && adv_n && $stable(count)) |=> $stable(cur.word))
    else $error("held burst word changed");
  a_busy_reset: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!rst_n && cur.op != OP_NONE) |=> !ready_busy_n [*3])
    else $error("busy released early after reset");
  a_soft_keep: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (rst_n && wr_end && cur.seq == 3'h0 && cmd == 8'hf0) |=> $stable(cur.burst))
    else $error("reset command changed burst mode");
endmodule : burst_flash_read_interface

// ==== tb/host_bus_model.sv ====
/*
  Host bus model: drives the flash pins like a slow processor bus.
  Assumes sys_clk at 50 MHz; burst clock made here, idle low.
*/
`timescale 1ns/100ps
module host_bus_model (
  input  wire logic        sys_clk,
  output logic             chip_select_n,
  output logic             output_gate_n,
  output logic             write_strobe_n,
  output logic             burst_clk,
  output logic             start_address_load_n,
  output logic             burst_advance_n,
  output logic [18:0]      addr,
  output logic [15:0]      data_in
);
  initial begin
    chip_select_n = 1'b1;
    output_gate_n = 1'b1;
    write_strobe_n = 1'b1;
    burst_clk = 1'b0;
    start_address_load_n = 1'b1;
    burst_advance_n = 1'b1;
    addr = 19'h00000;
    data_in = 16'h0000;
  end
  task automatic wr(input logic [18:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    chip_select_n <= 1'b0;
    output_gate_n <= 1'b1;
    write_strobe_n <= 1'b0;
    addr <= a;
    data_in <= d;
    repeat (4) @(posedge sys_clk);
    write_strobe_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    data_in <= ~d; // Released bus must not keep the old word
  endtask : wr
  task automatic cmd(input logic [7:0] c);
    wr(19'h00555, 16'h00aa);
    wr(19'h002aa, 16'h0055);
    wr(19'h00555, {8'h00, c});
  endtask : cmd
  task automatic pins(input logic cs_n, input logic oe_n,
                      input logic adv_n, input logic [18:0] a);
    @(posedge sys_clk);
    chip_select_n <= cs_n;
    output_gate_n <= oe_n;
    burst_advance_n <= adv_n;
    addr <= a;
    repeat (7) @(posedge sys_clk);
  endtask : pins
  // Pins set up before the rise; slow clock suits the synchroniser
  task automatic bclk(input logic ld_n, input logic adv_n);
    @(posedge sys_clk);
    start_address_load_n <= ld_n;
    burst_advance_n <= adv_n;
    repeat (2) @(posedge sys_clk);
    burst_clk <= 1'b1;
    repeat (5) @(posedge sys_clk);
    burst_clk <= 1'b0;
    start_address_load_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask : bclk
endmodule : host_bus_model

// ==== tb/burst_flash_read_interface_tb.sv ====
/*
  Self-checking bench: host model drives pins, a memory function
  answers array_addr, a monitor compares noted expectations.
*/
`timescale 1ns/100ps
`include "burst_flash_regs.svh"
`define CHECK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  fail_count++; $display("BAD %s exp %h seen %h", nm, e, g); end end
module burst_flash_read_interface_tb;
  typedef struct { int id; logic [15:0] val; } note_t;
  logic sys_clk = 1'b0, sys_rst = 1'b1, hw_reset_n = 1'b1;
  logic cs_n, oe_n, we_n, bclk, ld_n, adv_n, prog_req, pd_got;
  logic [18:0] addr, array_addr, base;
  logic [15:0] data_in, data_out, prog_data, pd_seen, seen, dval;
  logic data_oe_n, last_word_flag_n, ready_busy_n, burst_mode, asleep;
  int fail_count = 0, checks_done = 0, seed = 32'hfe91, k;
  note_t notes[$];
  note_t cur;
  string nm;
  always #10 sys_clk = ~sys_clk;
  function automatic logic [15:0] mem(input logic [18:0] a);
    return a[15:0] ^ {a[18:16], 13'h1b3};
  endfunction : mem
  host_bus_model u_host_bus_model (.sys_clk(sys_clk),
    .chip_select_n(cs_n), .output_gate_n(oe_n), .write_strobe_n(we_n),
    .burst_clk(bclk), .start_address_load_n(ld_n),
    .burst_advance_n(adv_n), .addr(addr), .data_in(data_in));
  burst_flash_read_interface #(.READY_CYCLES(20), .OP_CYCLES(20),
    .MFR_ID(16'h00c3), // Arbitrary value
    .DEV_ID(16'h003c)) // Arbitrary value
  u_burst_flash_read_interface (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .chip_select_n(cs_n), .output_gate_n(oe_n), .write_strobe_n(we_n),
    .hw_reset_n(hw_reset_n), .burst_clk(bclk),
    .start_address_load_n(ld_n), .burst_advance_n(adv_n),
    .addr(addr), .data_in(data_in), .array_data(mem(array_addr)),
    .data_out(data_out), .data_oe_n(data_oe_n),
    .array_addr(array_addr), .last_word_flag_n(last_word_flag_n),
    .ready_busy_n(ready_busy_n), .burst_mode(burst_mode),
    .asleep(asleep), .prog_req(prog_req), .prog_data(prog_data));
  task automatic note(input int id, input logic [15:0] v);
    notes.push_back('{id, v});
  endtask : note
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // Program pulse lasts one cycle, so catch it as it appears
  always @(posedge sys_clk) begin
    if (prog_req === 1'b1) begin
      pd_seen <= prog_data;
      pd_got <= 1'b1;
    end
  end
  always @(negedge sys_clk) begin
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      case (cur.id)
        0: begin nm = "data_out"; seen = data_out; end
        1: begin nm = "data_oe_n"; seen = {15'h0, data_oe_n}; end
        2: begin nm = "flag_n"; seen = {15'h0, last_word_flag_n}; end
        3: begin nm = "burst_mode"; seen = {15'h0, burst_mode}; end
        4: begin nm = "ready_n"; seen = {15'h0, ready_busy_n}; end
        5: begin nm = "prog_data"; seen = pd_seen; end
        6: begin nm = "status"; seen = data_out & 16'h00bf; end
        8: begin nm = "asleep"; seen = {15'h0, asleep}; end
        default: begin nm = "id_byte"; seen = {8'h00, data_out[7:0]}; end
      endcase
      `CHECK(nm, cur.val, seen)
    end
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    pd_got = 1'b0;
    pd_seen = 16'h0000;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    base = $random(seed);
    base[4:0] = 5'h1e;
    u_host_bus_model.pins(1'b0, 1'b0, 1'b1, base);
    note(0, mem(base));
    note(1, 16'h0000);
    note(8, 16'h0001);
    u_host_bus_model.bclk(1'b0, 1'b0);
    note(3, 16'h0000);
    u_host_bus_model.cmd(8'h78);
    note(3, 16'h0001);
    u_host_bus_model.pins(1'b0, 1'b0, 1'b1, base);
    u_host_bus_model.bclk(1'b0, 1'b1);
    note(0, mem(base));
    note(2, 16'h0001);
    u_host_bus_model.bclk(1'b1, 1'b0);
    note(0, mem({base[18:5], 5'h1f}));
    note(2, 16'h0001);
    u_host_bus_model.bclk(1'b1, 1'b0);
    note(0, mem({base[18:5], 5'h00}));
    note(2, 16'h0001);
    u_host_bus_model.pins(1'b0, 1'b1, 1'b1, base);
    note(1, 16'h0001);
    u_host_bus_model.bclk(1'b1, 1'b1);
    u_host_bus_model.pins(1'b0, 1'b0, 1'b1, base);
    note(0, mem({base[18:5], 5'h00}));
    note(1, 16'h0000);
    u_host_bus_model.bclk(1'b1, 1'b0);
    note(0, mem({base[18:5], 5'h01}));
    for (k = 0; k < 28; k++) u_host_bus_model.bclk(1'b1, 1'b0);
    note(0, mem({base[18:5], 5'h1d}));
    note(2, 16'h0000);
    u_host_bus_model.bclk(1'b1, 1'b0);
    note(0, mem(base));
    note(2, 16'h0001);
    u_host_bus_model.pins(1'b1, 1'b0, 1'b1, base);
    note(1, 16'h0001);
    note(3, 16'h0001);
    base = $random(seed);
    u_host_bus_model.pins(1'b0, 1'b0, 1'b1, base);
    u_host_bus_model.bclk(1'b0, 1'b1);
    note(0, mem(base));
    u_host_bus_model.pins(1'b1, 1'b0, 1'b1, base);
    u_host_bus_model.cmd(8'h90);
    for (k = 0; k < 3; k++) begin
      u_host_bus_model.pins(1'b0, 1'b0, 1'b1, (k == 2) ? 19'h3 : 19'(k));
      note(7, (k == 0) ? 16'h00c3 : (k == 1) ? 16'h003c : 16'h0001);
    end
    u_host_bus_model.wr(19'h00000, 16'h00f0);
    note(3, 16'h0001);
    dval = $random(seed);
    u_host_bus_model.cmd(8'h20);
    u_host_bus_model.wr(19'h00555, 16'h00a0);
    u_host_bus_model.wr(base, dval);
    for (k = 0; k < 20 && pd_got !== 1'b1; k++) @(posedge sys_clk);
    if (pd_got !== 1'b1) begin
      fail_count++;
      tally_and_finish();
    end
    note(5, dval);
    note(4, 16'h0000);
    u_host_bus_model.pins(1'b0, 1'b0, 1'b1, base);
    note(6, 16'h0000);
    repeat (40) @(posedge sys_clk);
    note(4, 16'h0001);
    u_host_bus_model.cmd(8'h70);
    note(3, 16'h0000);
    u_host_bus_model.cmd(8'h78);
    u_host_bus_model.wr(19'h00555, 16'h00a0);
    u_host_bus_model.wr(base, dval);
    u_host_bus_model.pins(1'b0, 1'b0, 1'b1, base);
    hw_reset_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    note(4, 16'h0000);
    repeat (20) @(posedge sys_clk);
    note(1, 16'h0001);
    note(3, 16'h0000);
    hw_reset_n <= 1'b1;
    repeat (12) @(posedge sys_clk);
    note(0, mem(base));
    note(4, 16'h0001);
    repeat (2) @(posedge sys_clk);
    tally_and_finish();
  end
endmodule : burst_flash_read_interface_tb
